/* File: sbcd_blk_ram.sv */
// Holds one host-written block image; read data come out of a register.
// Assumes write addresses are already range checked by the user.
`timescale 1ns/10ps
module sbcd_blk_ram
    import sbcd_pkg::*;
(
    input wire logic clk,
    sbcd_ram_if.ram bus
);
    logic [SBCD_WORD_W-1:0] mem [SBCD_BLK_WORDS];
    logic [SBCD_WORD_W-1:0] rdata_q;

    always_ff @(posedge clk)
    begin
        if (bus.we)
        begin
            mem[bus.waddr] <= bus.wdata;
        end
        rdata_q <= mem[bus.raddr];
    end

    assign bus.rdata = rdata_q;
endmodule : sbcd_blk_ram

/* File: sbcd_decoder.sv */
// Special block command decoder: decodes host-written special function blocks.
// Assumes the host, the command queue and the configuration store share clk.
// How it works
// - Word 0 of each host block is its identifier and selects the decoding.
// - Block 9002 puts up to six host-built commands into the command queue.
// - Commands queued by special blocks are marked high priority.
// - User commands are ten words each from word 2; six fields used.
// - Block 9003 queues stored command-list entries by their index.
// - Entries queued by 9003 run even when their enable code is zero.
// - Block 9003 produces no response block.
// - Index blocks hold a count up to 60 in word 1, indexes from word 2.
// - Blocks 9010 to 9012 handle only as many indexes as word 1 says.
// - Block 9010 sets enable code zero on listed entries.
// - Block 9011 sets enable code one on listed entries.
// - Block 9012 sets enable code two on listed entries.
// - Write-back request returns present configuration as response blocks.
// - General response: -9000 twice, then 47 configuration words from word 2.
// - Device responses -9100 to -9103: code twice, eight-word definitions from word 2.
`timescale 1ns/10ps
module sbcd_decoder
    import sbcd_pkg::*;
#(
    parameter logic [15:0] WRCFG_CODE = SBCD_CODE_WRCFG_DEF
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic blk_wr_valid,
    input wire logic [SBCD_ADDR_W-1:0] blk_wr_addr,
    input wire logic [SBCD_WORD_W-1:0] blk_wr_data,
    input wire logic blk_done,
    output logic blk_ready,
    input wire logic q_full,
    output logic q_valid,
    output logic q_high_prio,
    output logic q_by_index,
    output logic q_run_disabled,
    output logic [SBCD_ADDR_W-1:0] q_index,
    output logic [SBCD_UCMD_NF-1:0][SBCD_WORD_W-1:0] q_cmd,
    output logic en_valid,
    output logic [SBCD_ADDR_W-1:0] en_index,
    output logic [1:0] en_code,
    output logic [SBCD_CFG_AW-1:0] cfg_rd_addr,
    input wire logic [SBCD_WORD_W-1:0] cfg_rd_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [SBCD_WORD_W-1:0] rsp_data,
    output logic rsp_last
);
    typedef struct packed {
        sbcd_state_t st;
        logic [15:0] code;
        logic [5:0] cnt;
        logic [5:0] item;
        logic [2:0] fld;
        logic [7:0] addr;
        logic [2:0] rblk;
        logic [7:0] rw;
        logic blk_ready;
        logic q_valid;
        logic q_high_prio;
        logic q_by_index;
        logic q_run_disabled;
        logic [7:0] q_index;
        logic [SBCD_UCMD_NF-1:0][15:0] q_cmd;
        logic en_valid;
        logic [7:0] en_index;
        logic [1:0] en_code;
        logic [9:0] cfg_addr;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic rsp_last;
    } sbcd_regs_t;

    sbcd_regs_t s_q;
    sbcd_regs_t s_d;
    sbcd_ram_if ram_bus ();

    // True for the blocks that carry an index list
    function automatic logic sbcd_is_list(input logic [15:0] code);
        return (code == SBCD_CODE_EXEC) || (code == SBCD_CODE_DIS)
            || (code == SBCD_CODE_EN1) || (code == SBCD_CODE_EN2);
    endfunction : sbcd_is_list

    // Payload length of a response block
    function automatic logic [7:0] sbcd_pay_len(input logic [2:0] blk);
        return (blk == 3'h0) ? SBCD_GEN_PAY_LEN : SBCD_DEV_PAY_LEN;
    endfunction : sbcd_pay_len

    // Configuration store address for a response word
    function automatic logic [9:0] sbcd_cfg_addr(input logic [2:0] blk, input logic [7:0] w);
        logic [9:0] off;
        off = {2'h0, w} - 10'h002;
        return (blk == 3'h0) ? off
            : SBCD_DEV_CFG_BASE + 10'({7'h00, blk - 3'h1} * 10'h078) + off;
    endfunction : sbcd_cfg_addr

    sbcd_blk_ram u_ram (
        .clk(clk),
        .bus(ram_bus.ram)
    );

    assign ram_bus.we = blk_wr_valid && s_q.blk_ready && (blk_wr_addr <= SBCD_BLK_LAST);
    assign ram_bus.waddr = blk_wr_addr;
    assign ram_bus.wdata = blk_wr_data;
    assign ram_bus.raddr = s_q.addr;

    always_comb
    begin
        logic [15:0] code_w;
        logic [7:0] plen;
        code_w = 16'h0000;
        plen = 8'h00;
        s_d = s_q;
        s_d.q_valid = 1'b0;
        s_d.en_valid = 1'b0;
        unique case (s_q.st)
            ST_IDLE:
            begin
                s_d.blk_ready = 1'b1;
                if (blk_done && s_q.blk_ready)
                begin
                    s_d.blk_ready = 1'b0;
                    s_d.addr = 8'h00;
                    s_d.st = ST_LD0;
                end
            end
            ST_LD0:
            begin
                s_d.addr = SBCD_W_COUNT;
                s_d.st = ST_LD1;
            end
            ST_LD1:
            begin
                s_d.code = ram_bus.rdata;
                s_d.addr = SBCD_W_LIST;
                s_d.st = ST_LD2;
            end
            ST_LD2:
            begin
                s_d.cnt = ram_bus.rdata[5:0];
                s_d.item = 6'h00;
                s_d.fld = 3'h0;
                s_d.st = ST_IDLE;
                if (ram_bus.rdata >= 16'h0001 && ((s_q.code == SBCD_CODE_USER
                    && ram_bus.rdata <= {10'h000, SBCD_USER_MAX}) || (sbcd_is_list(s_q.code)
                    && ram_bus.rdata <= {10'h000, SBCD_LIST_MAX})))
                begin
                    s_d.st = ST_CAP;
                end
                if (s_q.code == WRCFG_CODE)
                begin
                    s_d.rblk = 3'h0;
                    s_d.rw = 8'h00;
                    s_d.cfg_addr = sbcd_cfg_addr(3'h0, 8'h00);
                    s_d.st = ST_RFETCH;
                end
            end
            ST_FETCH:
            begin
                s_d.st = ST_CAP;
            end
            ST_CAP:
            begin
                if (s_q.code == SBCD_CODE_USER)
                begin
                    // gather six fields of one command
                    s_d.q_cmd[s_q.fld] = ram_bus.rdata;
                    s_d.fld = s_q.fld + 3'h1;
                    s_d.addr = s_q.addr + 8'h01;
                    s_d.st = ST_FETCH;
                    if (s_q.fld == SBCD_UCMD_LAST_F)
                    begin
                        s_d.addr = SBCD_W_LIST + 8'(SBCD_UCMD_WORDS * {2'h0, s_q.item + 6'h01});
                        s_d.st = ST_PUSH;
                    end
                end
                else
                begin
                    s_d.addr = s_q.addr + 8'h01;
                    s_d.item = s_q.item + 6'h01;
                    s_d.st = (s_q.item + 6'h01 == s_q.cnt) ? ST_IDLE : ST_FETCH;
                    if (ram_bus.rdata < {8'h00, SBCD_NUM_CMDS})
                    begin
                        if (s_q.code == SBCD_CODE_EXEC)
                        begin
                            s_d.q_valid = !q_full;
                            s_d.q_high_prio = 1'b1;
                            s_d.q_by_index = 1'b1;
                            s_d.q_run_disabled = 1'b1;
                            s_d.q_index = ram_bus.rdata[7:0];
                        end
                        else
                        begin
                            s_d.en_valid = 1'b1;
                            s_d.en_index = ram_bus.rdata[7:0];
                            s_d.en_code = (s_q.code == SBCD_CODE_EN1) ? SBCD_EN_ONE
                                : (s_q.code == SBCD_CODE_EN2) ? SBCD_EN_TWO : SBCD_EN_OFF;
                        end
                    end
                end
            end
            ST_PUSH:
            begin
                s_d.q_valid = !q_full;
                s_d.q_high_prio = 1'b1;
                s_d.q_by_index = 1'b0;
                s_d.q_run_disabled = 1'b0;
                s_d.q_index = 8'h00;
                s_d.fld = 3'h0;
                s_d.item = s_q.item + 6'h01;
                s_d.st = (s_q.item + 6'h01 == s_q.cnt) ? ST_IDLE : ST_FETCH;
            end
            ST_RFETCH:
            begin
                code_w = (s_q.rblk == 3'h0) ? SBCD_RSP_GEN
                    : SBCD_RSP_DEV0 - {13'h0000, s_q.rblk - 3'h1};
                plen = sbcd_pay_len(s_q.rblk);
                s_d.rsp_data = (s_q.rw < SBCD_W_LIST) ? code_w
                    : (s_q.rw - SBCD_W_LIST < plen) ? cfg_rd_data : 16'h0000;
                s_d.rsp_valid = 1'b1;
                s_d.rsp_last = (s_q.rw == SBCD_BLK_LAST);
                s_d.st = ST_REMIT;
            end
            ST_REMIT:
            begin
                if (rsp_ready)
                begin
                    s_d.rsp_valid = 1'b0;
                    s_d.rsp_last = 1'b0;
                    s_d.st = ST_RFETCH;
                    s_d.rw = s_q.rw + 8'h01;
                    if (s_q.rw == SBCD_BLK_LAST)
                    begin
                        s_d.rw = 8'h00;
                        s_d.rblk = s_q.rblk + 3'h1;
                        s_d.st = (s_q.rblk == SBCD_RSP_LAST_BLK) ? ST_IDLE : ST_RFETCH;
                    end
                    s_d.cfg_addr = sbcd_cfg_addr(s_d.rblk, s_d.rw);
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign blk_ready = s_q.blk_ready;
    assign q_valid = s_q.q_valid;
    assign q_high_prio = s_q.q_high_prio;
    assign q_by_index = s_q.q_by_index;
    assign q_run_disabled = s_q.q_run_disabled;
    assign q_index = s_q.q_index;
    assign q_cmd = s_q.q_cmd;
    assign en_valid = s_q.en_valid;
    assign en_index = s_q.en_index;
    assign en_code = s_q.en_code;
    assign cfg_rd_addr = s_q.cfg_addr;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_data = s_q.rsp_data;
    assign rsp_last = s_q.rsp_last;
endmodule : sbcd_decoder

/* File: sbcd_decoder_checker.sv */
// Concurrent checks on the special block command decoder ports.
// Assumes binding to sbcd_decoder; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module sbcd_decoder_checker
    import sbcd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic blk_done,
    input wire logic blk_ready,
    input wire logic q_full,
    input wire logic q_valid,
    input wire logic q_high_prio,
    input wire logic q_by_index,
    input wire logic q_run_disabled,
    input wire logic [SBCD_ADDR_W-1:0] q_index,
    input wire logic en_valid,
    input wire logic [SBCD_ADDR_W-1:0] en_index,
    input wire logic [1:0] en_code,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [SBCD_WORD_W-1:0] rsp_data,
    input wire logic rsp_last
);
    logic [7:0] word_q;
    logic [7:0] word_d;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Position of the response word inside its block
    always_comb
    begin
        word_d = word_q;
        if (rsp_valid && rsp_ready)
        begin
            word_d = (word_q == SBCD_BLK_LAST) ? 8'h00 : word_q + 8'h01;
        end
        if (!resetn)
        begin
            word_d = 8'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        word_q <= word_d;
    end

    sequence s_take;
        blk_done && blk_ready;
    endsequence

    sequence s_busy;
        !blk_ready [*4];
    endsequence

    done_busy_a: assert property (s_take |=> s_busy)
        else $error("decoder ready during block decode");
    prio_push_a: assert property (q_valid |-> q_high_prio)
        else $error("queue push without high priority");
    index_push_a: assert property (q_valid && q_by_index |-> q_run_disabled && q_index < SBCD_NUM_CMDS)
        else $error("bad index push");
    full_drop_a: assert property (q_valid |-> !$past(q_full))
        else $error("push into full queue");
    en_legal_a: assert property (en_valid |-> en_code != 2'h3 && en_index < SBCD_NUM_CMDS)
        else $error("bad enable write");
    push_gap_a: assert property (q_valid |=> !q_valid)
        else $error("back to back pushes");
    quiet_decode_a: assert property (q_valid || en_valid |-> !rsp_valid && !blk_ready)
        else $error("response or ready during decode action");
    rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("response word not held");
    rsp_last_a: assert property (rsp_valid |-> rsp_last == (word_q == SBCD_BLK_LAST))
        else $error("block end mark misplaced");
endmodule : sbcd_decoder_checker

bind sbcd_decoder sbcd_decoder_checker chk_u (.clk(clk), .resetn(resetn), .blk_done(blk_done),
    .blk_ready(blk_ready), .q_full(q_full), .q_valid(q_valid), .q_high_prio(q_high_prio),
    .q_by_index(q_by_index), .q_run_disabled(q_run_disabled), .q_index(q_index),
    .en_valid(en_valid), .en_index(en_index), .en_code(en_code), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));

/* File: sbcd_far_model.sv */
// Far side: configuration store and host taking response words.
// Assumes it shares clk with the decoder; store answers in the same cycle.
`timescale 1ns/10ps
module sbcd_far_model
    import sbcd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [SBCD_CFG_AW-1:0] cfg_rd_addr,
    output logic [SBCD_WORD_W-1:0] cfg_rd_data,
    input wire logic rsp_valid,
    input wire logic [SBCD_WORD_W-1:0] rsp_data,
    input wire logic rsp_last,
    output logic rsp_ready
);
    logic [1:0] stall_q;
    logic [16:0] got[$];

    assign cfg_rd_data = {6'h15, cfg_rd_addr};

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            stall_q <= 2'h0;
            rsp_ready <= 1'b0;
        end
        else
        begin
            stall_q <= stall_q + 2'h1;
            rsp_ready <= (stall_q != 2'h3);
            if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
            begin
                got.push_back({rsp_last, rsp_data});
            end
        end
    end
endmodule : sbcd_far_model

/* File: sbcd_pkg.sv */
// Constants, codes and types shared by the special block command decoder.
// Assumes 16-bit block words and a block image of 248 words.
package sbcd_pkg;
    localparam int SBCD_WORD_W = 16;
    localparam int SBCD_ADDR_W = 8;
    localparam int SBCD_BLK_WORDS = 248;
    localparam int SBCD_CFG_AW = 10;
    localparam int SBCD_UCMD_NF = 6;
    // Block identifiers
    localparam logic [15:0] SBCD_CODE_USER = 16'h232a;
    localparam logic [15:0] SBCD_CODE_EXEC = 16'h232b;
    localparam logic [15:0] SBCD_CODE_DIS = 16'h2332;
    localparam logic [15:0] SBCD_CODE_EN1 = 16'h2333;
    localparam logic [15:0] SBCD_CODE_EN2 = 16'h2334;
    localparam logic [15:0] SBCD_CODE_WRCFG_DEF = 16'h270d;
    localparam logic [15:0] SBCD_RSP_GEN = 16'hdcd8;
    localparam logic [15:0] SBCD_RSP_DEV0 = 16'hdc74;
    // Block layout
    localparam logic [7:0] SBCD_W_COUNT = 8'h01;
    localparam logic [7:0] SBCD_W_LIST = 8'h02;
    localparam logic [7:0] SBCD_UCMD_WORDS = 8'h0a;
    localparam logic [2:0] SBCD_UCMD_LAST_F = 3'h5;
    localparam logic [5:0] SBCD_USER_MAX = 6'h06;
    localparam logic [5:0] SBCD_LIST_MAX = 6'h3c;
    localparam logic [7:0] SBCD_NUM_CMDS = 8'hc8;
    localparam logic [7:0] SBCD_BLK_LAST = 8'hf7;
    // Write-back layout
    localparam logic [2:0] SBCD_RSP_LAST_BLK = 3'h4;
    localparam logic [7:0] SBCD_GEN_PAY_LEN = 8'h2f;
    localparam logic [7:0] SBCD_DEV_PAY_LEN = 8'h78;
    localparam logic [9:0] SBCD_DEV_CFG_BASE = 10'h02f;
    // Enable codes
    localparam logic [1:0] SBCD_EN_OFF = 2'h0;
    localparam logic [1:0] SBCD_EN_ONE = 2'h1;
    localparam logic [1:0] SBCD_EN_TWO = 2'h2;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_LD0 = 9'h002,
        ST_LD1 = 9'h004,
        ST_LD2 = 9'h008,
        ST_FETCH = 9'h010,
        ST_CAP = 9'h020,
        ST_PUSH = 9'h040,
        ST_RFETCH = 9'h080,
        ST_REMIT = 9'h100
    } sbcd_state_t;
endpackage : sbcd_pkg

/* File: sbcd_ram_if.sv */
// Port group between the decoder and its block image memory.
// Assumes the memory and the decoder share one clock.
`timescale 1ns/10ps
interface sbcd_ram_if;
    logic we;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [7:0] raddr;
    logic [15:0] rdata;
    modport ram (input we, input waddr, input wdata, input raddr, output rdata);
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
endinterface : sbcd_ram_if

/* File: testbench.sv */
// Self-checking bench for the special block command decoder.
// Assumes a 10 MHz clock and the far-side model for store and responses.
`timescale 1ns/10ps
module testbench
    import sbcd_pkg::*;
;
    logic clk, resetn, blk_wr_valid, blk_done, blk_ready, q_full, q_valid, q_high_prio;
    logic q_by_index, q_run_disabled, en_valid, rsp_valid, rsp_ready, rsp_last;
    logic [7:0] blk_wr_addr, q_index, en_index;
    logic [15:0] blk_wr_data, cfg_rd_data, rsp_data;
    logic [SBCD_UCMD_NF-1:0][SBCD_WORD_W-1:0] q_cmd;
    logic [1:0] en_code;
    logic [9:0] cfg_rd_addr;
    logic [9:0] enq[$];
    logic [10:0] qf[$];
    logic [SBCD_UCMD_NF-1:0][SBCD_WORD_W-1:0] qc[$];
    int bad_count = 0;
    int num_checks = 0;

    sbcd_decoder dut_u (.clk(clk), .resetn(resetn), .blk_wr_valid(blk_wr_valid),
        .blk_wr_addr(blk_wr_addr), .blk_wr_data(blk_wr_data), .blk_done(blk_done),
        .blk_ready(blk_ready), .q_full(q_full), .q_valid(q_valid), .q_high_prio(q_high_prio),
        .q_by_index(q_by_index), .q_run_disabled(q_run_disabled), .q_index(q_index),
        .q_cmd(q_cmd), .en_valid(en_valid), .en_index(en_index), .en_code(en_code),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));
    sbcd_far_model far_u (.clk(clk), .resetn(resetn), .cfg_rd_addr(cfg_rd_addr),
        .cfg_rd_data(cfg_rd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (en_valid === 1'b1)
        begin
            enq.push_back({en_index, en_code});
        end
        if (q_valid === 1'b1)
        begin
            qf.push_back({q_by_index, q_run_disabled, q_high_prio, q_index});
            qc.push_back(q_cmd);
        end
    end

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        blk_wr_valid <= 1'b1;
        blk_wr_addr <= a;
        blk_wr_data <= d;
    endtask : wr

    task wait_ready;
        for (int i = 0; i < 20000; i++)
        begin
            @(posedge clk);
            #1;
            if (blk_ready === 1'b1)
            begin
                break;
            end
        end
        check("ready", blk_ready, 1'b1);
    endtask : wait_ready

    task go(input logic [15:0] code, input logic [15:0] cnt);
        wr(8'h00, code);
        wr(8'h01, cnt);
        @(posedge clk);
        blk_wr_valid <= 1'b0;
        blk_done <= 1'b1;
        @(posedge clk);
        blk_done <= 1'b0;
        wait_ready();
    endtask : go

    task t_enable;
        for (int k = 0; k < 3; k++)
        begin
            enq.delete();
            wr(8'h02, 16'h0005);
            wr(8'h03, 16'h00c8);
            wr(8'h04, 16'h00c7);
            wr(8'h05, 16'h0009);
            go(SBCD_CODE_DIS + 16'(k), 16'h0003);
            check("en count", enq.size(), 2);
            check("en first", enq[0], {8'h05, 2'(k)});
            check("en last", enq[1], {8'hc7, 2'(k)});
        end
    endtask : t_enable

    task t_exec;
        qf.delete();
        for (int i = 0; i < 60; i++)
        begin
            wr(8'(2 + i), (i == 1) ? 16'h00fa : 16'(i));
        end
        go(SBCD_CODE_EXEC, 16'h003c);
        check("exec count", qf.size(), 59);
        for (int j = 0; j < 59; j++)
        begin
            check("index push", qf[j], {3'b111, 8'((j == 0) ? 0 : j + 1)});
        end
        check("no response", far_u.got.size(), 0);
    endtask : t_exec

    task t_user;
        qf.delete();
        qc.delete();
        for (int i = 0; i < 20; i++)
        begin
            wr(8'(2 + i), 16'h1000 + 16'(16 * (i / 10) + i % 10));
        end
        go(SBCD_CODE_USER, 16'h0002);
        check("user count", qf.size(), 2);
        for (int i = 0; i < 12; i++)
        begin
            check("user flags", qf[i / 6], {3'b001, 8'h00});
            check("cmd field", qc[i / 6][i % 6], 16'h1000 + 16'(16 * (i / 6) + i % 6));
        end
        @(posedge clk);
        q_full <= 1'b1;
        go(SBCD_CODE_USER, 16'h0001);
        check("full drop", qf.size(), 2);
        @(posedge clk);
        q_full <= 1'b0;
    endtask : t_user

    task t_bad;
        logic [15:0] codes [6];
        logic [15:0] cnts [6];
        codes = '{SBCD_CODE_USER, SBCD_CODE_USER, SBCD_CODE_EXEC, SBCD_CODE_EXEC,
            SBCD_CODE_DIS, 16'h2329};
        cnts = '{16'h0000, 16'h0007, 16'h0000, 16'h003d, 16'h003d, 16'h0001};
        qf.delete();
        enq.delete();
        for (int k = 0; k < 6; k++)
        begin
            go(codes[k], cnts[k]);
            check("ignored block", qf.size() + enq.size(), 0);
        end
    endtask : t_bad

    task t_wrback;
        logic [16:0] exp;
        int a;
        go(SBCD_CODE_WRCFG_DEF, 16'h0000);
        check("rsp words", far_u.got.size(), 1240);
        for (int n = 0; n < 1240; n++)
        begin
            a = (n < 248) ? n - 2 : 45 + (n / 248 - 1) * 120 + n % 248;
            exp = {n % 248 == 247, 16'h0000};
            if (n % 248 < 2)
            begin
                exp[15:0] = (n < 248) ? SBCD_RSP_GEN : SBCD_RSP_DEV0 - 16'(n / 248 - 1);
            end
            else if (n % 248 < ((n < 248) ? 49 : 122))
            begin
                exp[15:0] = {6'h15, 10'(a)};
            end
            check("rsp word", far_u.got[n], exp);
        end
    endtask : t_wrback

    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        resetn = 1'b0;
        blk_wr_valid = 1'b0;
        blk_wr_addr = 8'h00;
        blk_wr_data = 16'h0000;
        blk_done = 1'b0;
        q_full = 1'b0;
        repeat (16) @(posedge clk);
        check("ready in reset", blk_ready, 1'b0);
        resetn <= 1'b1;
        wait_ready();
        t_enable();
        t_exec();
        t_user();
        t_bad();
        t_wrback();
        report_and_stop();
    end
endmodule : testbench
